// ===== logic/adc_scan_pkg.sv
package adc_scan_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int COEF_FRAC_BITS = 16;

   localparam logic [ADDR_W-1:0] OFS_HARM_COEF = 8'h3C;
   localparam logic [ADDR_W-1:0] OFS_CONV_CFG = 8'h4C;
   localparam logic [ADDR_W-1:0] OFS_CONV_INTERVAL = 8'h4E;
   localparam logic [ADDR_W-1:0] OFS_SETTLE = 8'h50;
   localparam logic [ADDR_W-1:0] OFS_ZERO_CROSS_LOWPASS = 8'h5A;

   localparam int CFG_KEEP_BIT = 7;
   localparam int CFG_DONE_BIT = 6;
   localparam int CFG_DIV_HI = 5;
   localparam int CFG_DIV_LO = 4;
   localparam int CFG_ACTIVE_BIT = 3;
   localparam int CFG_IRQ_EN_BIT = 2;
   localparam int CFG_REF_BIT = 1;
   localparam int CFG_ON_BIT = 0;

   localparam logic [31:0] HARM_RESET = 32'h0000_1831;
   localparam logic [7:0] CFG_RESET = 8'h07;
   localparam logic [15:0] INTERVAL_RESET = 16'h0167;
   localparam logic [15:0] SETTLE_RESET = 16'h002F;
   localparam logic [15:0] ZC_RESET = 16'h3B00;

   localparam logic [1:0] DIV_BY1 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   localparam logic [1:0] DIV_BY4 = 2'h2;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_SETTLE = 3'b010,
      SEQ_CONVERT = 3'b100
   } seq_state_e;
endpackage

// ===== logic/seq_if.sv
`timescale 1ns/1ns
interface seq_if #(parameter int W = 16);
   logic enable;
   logic [W-1:0] interval;
   logic [W-1:0] settle;
   logic conv_end;
   logic mux_switch;
   logic busy;
   logic settling;
   logic complete;
   modport ctrl (output enable, interval, settle, conv_end,
                 input mux_switch, busy, settling, complete);
   modport seq (input enable, interval, settle, conv_end,
                output mux_switch, busy, settling, complete);
endinterface

// ===== logic/converter_sequencer.sv
`timescale 1ns/1ns
module converter_sequencer
   import adc_scan_pkg::*;
#(
   parameter int CW = CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control side
   seq_if.seq sq
);
   seq_state_e state_reg, state_next;
   logic [CW-1:0] ivl_reg, ivl_next, stl_reg, stl_next;
   logic mux_reg, busy_reg, settling_reg, complete_reg;
   wire fire = sq.enable && (ivl_reg >= sq.interval);
   wire settled = (stl_reg >= sq.settle);

   // Free-running spacing keeps the start rate fixed even when a cycle is skipped
   assign ivl_next = (!sq.enable || fire) ? '0 : CW'(ivl_reg + 1'b1);
   assign stl_next = (state_reg == SEQ_SETTLE) ? CW'(stl_reg + 1'b1) : '0;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SEQ_IDLE: if (fire) state_next = SEQ_SETTLE;
         SEQ_SETTLE: if (settled) state_next = SEQ_CONVERT;
         SEQ_CONVERT: if (sq.conv_end) state_next = SEQ_IDLE;
         default: state_next = SEQ_IDLE;
      endcase
      if (!sq.enable) state_next = SEQ_IDLE;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= SEQ_IDLE;
         ivl_reg <= '0;
         stl_reg <= '0;
         mux_reg <= 1'b0;
         busy_reg <= 1'b0;
         settling_reg <= 1'b0;
         complete_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ivl_reg <= ivl_next;
         stl_reg <= stl_next;
         mux_reg <= (state_reg == SEQ_IDLE) && (state_next == SEQ_SETTLE);
         busy_reg <= (state_next == SEQ_CONVERT);
         settling_reg <= (state_next == SEQ_SETTLE);
         complete_reg <= (state_reg == SEQ_CONVERT) && sq.conv_end && sq.enable;
      end
   end

   assign sq.mux_switch = mux_reg;
   assign sq.busy = busy_reg;
   assign sq.settling = settling_reg;
   assign sq.complete = complete_reg;

   // Helper counters for checking spacing
   logic [CW:0] since_mux, since_fire;
   logic seen_fire;
   logic [CW-1:0] interval_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         since_mux <= '0;
         since_fire <= '0;
         seen_fire <= 1'b0;
         interval_q <= '0;
      end else begin
         since_mux <= mux_reg ? (CW+1)'(1) : (CW+1)'(since_mux + 1'b1);
         since_fire <= fire ? (CW+1)'(1) : (CW+1)'(since_fire + 1'b1);
         interval_q <= sq.interval;
         seen_fire <= sq.enable && (seen_fire || fire) && (sq.interval == interval_q);
      end
   end

   a_fire_spacing:
      assert property (@(posedge clk) disable iff (reset)
         (fire && seen_fire && sq.interval == interval_q) |-> since_fire == sq.interval + 1'b1)
      else $error("conversion start spacing differs from interval plus one");

   a_settle_length:
      assert property (@(posedge clk) disable iff (reset)
         ($rose(sq.busy) && $stable(sq.settle)) |-> since_mux == sq.settle + 1'b1)
      else $error("settling delay differs from settle value plus one");
endmodule // converter_sequencer

// ===== logic/adc_scan_control_regs.sv
`timescale 1ns/1ns
module adc_scan_control_regs
   import adc_scan_pkg::*;
#(
   parameter logic [31:0] HARM_INIT = HARM_RESET,
   parameter logic [15:0] INTERVAL_INIT = INTERVAL_RESET,
   parameter logic [15:0] SETTLE_INIT = SETTLE_RESET,
   parameter logic [15:0] ZC_INIT = ZC_RESET
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register access port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   // Converter front end
   input wire logic conv_end,
   output logic mux_switch,
   output logic conversion_active,
   output logic analog_power_on,
   output logic converter_enable,
   output logic converter_clk_tick,
   output logic reference_output_pin,
   output logic conversion_irq,
   // Filter coefficients
   output logic [15:0] harmonic_feedback_coef_int,
   output logic [15:0] harmonic_feedback_coef_frac,
   output logic [15:0] zero_cross_smoothing
);
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [31:0] harm_reg;
   logic [15:0] interval_reg, settle_reg, zc_reg;
   logic keep_reg, done_reg, irq_en_reg, ref_reg, on_reg;
   logic [1:0] div_reg;
   logic [1:0] div_cnt_reg;
   logic tick_reg, power_reg, ref_out_reg, enable_out_reg, irq_reg;
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   seq_if #(.W(CNT_W)) sq ();

   converter_sequencer #(.CW(CNT_W)) u_seq (
      .clk(clk),
      .reset(reset),
      .sq(sq)
   );

   assign sq.enable = on_reg;
   assign sq.interval = interval_reg;
   assign sq.settle = settle_reg;
   assign sq.conv_end = conv_end;

   wire wr_harm = reg_wr && hit(reg_addr, OFS_HARM_COEF);
   wire wr_cfg = reg_wr && hit(reg_addr, OFS_CONV_CFG);
   wire wr_ivl = reg_wr && hit(reg_addr, OFS_CONV_INTERVAL);
   wire wr_stl = reg_wr && hit(reg_addr, OFS_SETTLE);
   wire wr_zc = reg_wr && hit(reg_addr, OFS_ZERO_CROSS_LOWPASS);
   // A zero write clears, a one write leaves the flag alone
   wire done_clear = wr_cfg && !reg_wdata[CFG_DONE_BIT];
   // Completion in the clearing cycle still sets the flag
   wire done_next = sq.complete || (done_reg && !done_clear);

   wire [7:0] cfg_view = {keep_reg, done_reg, div_reg, sq.busy, irq_en_reg, ref_reg, on_reg};

   // Reserved code 11 falls back to the slowest rate
   wire tick_next = on_reg && ((div_reg == DIV_BY1) ||
                   ((div_reg == DIV_BY2) && div_cnt_reg[0]) ||
                   ((div_reg != DIV_BY1) && (div_reg != DIV_BY2) && (div_cnt_reg == 2'h3)));
   // Analog section is kept up while settling and converting
   wire power_next = on_reg && (sq.busy || sq.settling || keep_reg);
   wire irq_next = done_reg && irq_en_reg;

   always_comb begin
      rdata_next = '0;
      if (hit(reg_addr, OFS_HARM_COEF)) rdata_next = harm_reg;
      else if (hit(reg_addr, OFS_CONV_CFG)) rdata_next = {24'h000000, cfg_view};
      else if (hit(reg_addr, OFS_CONV_INTERVAL)) rdata_next = {16'h0000, interval_reg};
      else if (hit(reg_addr, OFS_SETTLE)) rdata_next = {16'h0000, settle_reg};
      else if (hit(reg_addr, OFS_ZERO_CROSS_LOWPASS)) rdata_next = {16'h0000, zc_reg};
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         harm_reg <= HARM_INIT;
         interval_reg <= INTERVAL_INIT;
         settle_reg <= SETTLE_INIT;
         zc_reg <= ZC_INIT;
      end else begin
         if (wr_harm) harm_reg <= reg_wdata;
         if (wr_ivl) interval_reg <= reg_wdata[15:0];
         if (wr_stl) settle_reg <= reg_wdata[15:0];
         if (wr_zc) zc_reg <= reg_wdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         keep_reg <= CFG_RESET[CFG_KEEP_BIT];
         div_reg <= CFG_RESET[CFG_DIV_HI:CFG_DIV_LO];
         irq_en_reg <= CFG_RESET[CFG_IRQ_EN_BIT];
         ref_reg <= CFG_RESET[CFG_REF_BIT];
         on_reg <= CFG_RESET[CFG_ON_BIT];
         done_reg <= CFG_RESET[CFG_DONE_BIT];
      end else begin
         if (wr_cfg) begin
            keep_reg <= reg_wdata[CFG_KEEP_BIT];
            div_reg <= reg_wdata[CFG_DIV_HI:CFG_DIV_LO];
            irq_en_reg <= reg_wdata[CFG_IRQ_EN_BIT];
            ref_reg <= reg_wdata[CFG_REF_BIT];
            on_reg <= reg_wdata[CFG_ON_BIT];
         end
         done_reg <= done_next;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_cnt_reg <= 2'h0;
         tick_reg <= 1'b0;
         power_reg <= 1'b0;
         ref_out_reg <= 1'b0;
         enable_out_reg <= 1'b0;
         irq_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         div_cnt_reg <= 2'(div_cnt_reg + 1'b1);
         tick_reg <= tick_next;
         power_reg <= power_next;
         ref_out_reg <= ref_reg;
         enable_out_reg <= on_reg;
         irq_reg <= irq_next;
         if (reg_rd) rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign mux_switch = sq.mux_switch;
   assign conversion_active = sq.busy;
   assign analog_power_on = power_reg;
   assign converter_enable = enable_out_reg;
   assign converter_clk_tick = tick_reg;
   assign reference_output_pin = ref_out_reg;
   assign conversion_irq = irq_reg;
   // Integer part above the binary point, sixteen fraction bits below
   assign harmonic_feedback_coef_int = harm_reg[31:COEF_FRAC_BITS];
   assign harmonic_feedback_coef_frac = harm_reg[COEF_FRAC_BITS-1:0];
   // MSB passes unchanged; a set MSB is the writer's fault
   assign zero_cross_smoothing = zc_reg;

   a_coef_split:
      assert property (@(posedge clk) disable iff (reset)
         wr_harm |=> (harmonic_feedback_coef_int == $past(reg_wdata[31:16]))
                  && (harmonic_feedback_coef_frac == $past(reg_wdata[15:0])))
      else $error("harmonic coefficient split wrong");

   a_power_down:
      assert property (@(posedge clk) disable iff (reset)
         (sq.complete && !keep_reg) |=> !analog_power_on)
      else $error("analog section stayed on after conversion");

   a_power_kept:
      assert property (@(posedge clk) disable iff (reset)
         (keep_reg && on_reg) |=> analog_power_on)
      else $error("analog section off although kept powered");

   a_done_sets:
      assert property (@(posedge clk) disable iff (reset)
         sq.complete |=> done_reg)
      else $error("done flag not set after completion");

   a_irq_raise:
      assert property (@(posedge clk) disable iff (reset)
         (sq.complete && irq_en_reg) ##1 irq_en_reg |=> conversion_irq)
      else $error("interrupt missing after completion");

   a_div_one:
      assert property (@(posedge clk) disable iff (reset)
         (div_reg == DIV_BY1 && on_reg)[*2] |-> converter_clk_tick)
      else $error("divide by one tick missing");

   a_div_four:
      assert property (@(posedge clk) disable iff (reset)
         (div_reg == DIV_BY4 && on_reg)[*5] |-> $countones({converter_clk_tick,
            $past(converter_clk_tick), $past(converter_clk_tick, 2),
            $past(converter_clk_tick, 3)}) == 1)
      else $error("divide by four rate wrong");

   a_busy_end:
      assert property (@(posedge clk) disable iff (reset)
         $fell(conversion_active) |-> (sq.complete || !$past(on_reg)))
      else $error("busy cleared without end of conversion");

   a_ref_follow:
      assert property (@(posedge clk) disable iff (reset)
         (wr_cfg && reg_wdata[CFG_REF_BIT]) ##1 ref_reg |=> reference_output_pin)
      else $error("reference buffer not enabled");

   a_off_idle:
      assert property (@(posedge clk) disable iff (reset)
         (!on_reg)[*2] |-> (!conversion_active && !analog_power_on && !converter_clk_tick))
      else $error("converter active while switched off");

   a_done_clear:
      assert property (@(posedge clk) disable iff (reset)
         (done_clear && !sq.complete) |=> !done_reg)
      else $error("done flag not cleared by zero write");
endmodule // adc_scan_control_regs

// ===== tb/conv_front_end.sv
`timescale 1ns/1ns
module conv_front_end (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Converter handshake
   input wire logic conversion_active,
   input wire logic [7:0] latency,
   output logic conv_end
);
   logic [7:0] cnt_reg;
   // One-cycle finish strobe, only ever raised inside a conversion
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= 8'h00;
         conv_end <= 1'b0;
      end else begin
         conv_end <= conversion_active && !conv_end && cnt_reg == latency;
         cnt_reg <= (conversion_active && !conv_end) ? cnt_reg + 8'h01 : 8'h00;
      end
   end
endmodule // conv_front_end

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import adc_scan_pkg::*;
   logic clk = 0;
   logic reset = 1;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic [DATA_W-1:0] reg_rdata;
   logic [DATA_W-1:0] rd_val;
   logic conv_end, mux_switch, conversion_active, analog_power_on, converter_enable;
   logic converter_clk_tick, reference_output_pin, conversion_irq;
   logic [15:0] harmonic_feedback_coef_int, harmonic_feedback_coef_frac, zero_cross_smoothing;
   logic [7:0] lat = 8'h03;
   logic [7:0] ra [6] = '{OFS_HARM_COEF, OFS_CONV_CFG, OFS_CONV_INTERVAL, OFS_SETTLE,
                          OFS_ZERO_CROSS_LOWPASS, 8'h41};
   logic [31:0] rv [6] = '{32'h1831, 32'h07, 32'h167, 32'h2F, 32'h3B00, 32'h0};
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   int ticks = 0;
   int muxes = 0;
   int t0, n, seed;
   int harm_m, zc_m;
   int ival = 40;
   int sval = 3;
   logic keep, irq;

   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      // Outputs are unknown before the first reset edge; keep the counts clean
      if (!reset) begin
         ticks <= ticks + converter_clk_tick;
         muxes <= muxes + mux_switch;
      end
   end

   adc_scan_control_regs dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_end(conv_end),
      .mux_switch(mux_switch), .conversion_active(conversion_active),
      .analog_power_on(analog_power_on), .converter_enable(converter_enable),
      .converter_clk_tick(converter_clk_tick), .reference_output_pin(reference_output_pin),
      .conversion_irq(conversion_irq), .harmonic_feedback_coef_int(harmonic_feedback_coef_int),
      .harmonic_feedback_coef_frac(harmonic_feedback_coef_frac),
      .zero_cross_smoothing(zero_cross_smoothing));
   conv_front_end fe (.clk(clk), .reset(reset), .conversion_active(conversion_active),
      .latency(lat), .conv_end(conv_end));

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd_val = reg_rdata;
   endtask
   function automatic logic pick(int which);
      case (which)
         0: pick = mux_switch;
         1: pick = conversion_active;
         default: pick = conv_end;
      endcase
   endfunction
   task automatic wait_for(int which);
      int k;
      k = 0;
      while (pick(which) !== 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      if (k == 2000) begin
         miscompares++;
         $display("MISMATCH at %0t: no response", $time);
      end
   endtask
   task automatic final_report;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(100 * 30000);
      miscompares++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      final_report;
   end

   initial begin
      seed = 32'hf19d;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         check(rd_val, rv[i]);
      end
      check(reference_output_pin, 1'b1);
      check(converter_enable, 1'b1);
      harm_m = $random(seed);
      wr(OFS_HARM_COEF, harm_m);
      rd(OFS_HARM_COEF);
      check(rd_val, harm_m);
      check({harmonic_feedback_coef_int, harmonic_feedback_coef_frac}, harm_m);
      // Writers keep the top bit clear
      zc_m = $random(seed) & 32'h7FFF;
      wr(OFS_ZERO_CROSS_LOWPASS, zc_m);
      wr(8'h41, 32'hFFFF_FFFF);
      rd(OFS_ZERO_CROSS_LOWPASS);
      check(rd_val, zc_m);
      check(zero_cross_smoothing, zc_m);
      rd(8'h41);
      check(rd_val, 32'h0);
      // Flag bits are not host-settable; converter off keeps busy low
      wr(OFS_CONV_CFG, 32'hFE);
      rd(OFS_CONV_CFG);
      check(rd_val, 32'hB6);
      check(reference_output_pin, 1'b1);
      check(converter_enable, 1'b0);
      t0 = ticks;
      n = muxes;
      repeat (400) @(negedge clk);
      check(ticks - t0, 0);
      check(muxes - n, 0);
      wr(OFS_CONV_CFG, 32'h00);
      rd(OFS_CONV_CFG);
      check(reference_output_pin, 1'b0);
      // Stands in for the CPU side, which owns these mirrors
      wr(OFS_CONV_INTERVAL, ival);
      wr(OFS_SETTLE, sval);
      for (int d = 0; d < 4; d++) begin
         wr(OFS_CONV_CFG, (d << 4) | 1);
         // Let the tick computed from the old setting drain first
         repeat (2) @(negedge clk);
         t0 = ticks;
         repeat (16) @(negedge clk);
         check(ticks - t0, (d == 0) ? 16 : (d == 1) ? 8 : 4);
      end
      wr(OFS_CONV_CFG, 32'h00);
      for (int k = 0; k < 4; k++) begin
         keep = k[0];
         irq = k[1];
         lat = 8'h01 + 8'($unsigned($random(seed)) % 8);
         wr(OFS_CONV_CFG, {24'h0, keep, 3'h0, 1'b0, irq, 2'h3});
         wait_for(0);
         t0 = cyc;
         @(negedge clk);
         wait_for(1);
         check(cyc - t0, sval + 1);
         check(analog_power_on, 1'b1);
         wait_for(2);
         @(negedge clk);
         check(conversion_active, 1'b0);
         @(negedge clk);
         check(analog_power_on, keep);
         @(negedge clk);
         check(conversion_irq, irq);
         rd(OFS_CONV_CFG);
         check(rd_val[6], 1'b1);
         wait_for(0);
         check(cyc - t0, ival + 1);
         wr(OFS_CONV_CFG, {29'h0, irq, 2'h2});
         rd(OFS_CONV_CFG);
         check(rd_val[6], 1'b0);
         check(conversion_irq, 1'b0);
      end
      final_report;
   end
endmodule // testbench
